// ### shared/burst_seq_regs.vh
// Constants for the read and write burst sequencer.
`ifndef BURST_SEQ_REGS_VH
`define BURST_SEQ_REGS_VH
// Burst field encodings of mode register zero.
`define BURST_FIXED_EIGHT 2'h0
`define BURST_PER_COMMAND 2'h1
`define BURST_FIXED_CHOP 2'h2
// Beat counts for the two burst lengths.
`define BEATS_EIGHT 4'h8
`define BEATS_CHOP 4'h4
// Read latency limits in clocks.
`define READ_LATENCY_MAX 6'h3f
`define READ_LATENCY_RESET 6'h0b
// Write latency reset value in clocks.
`define WRITE_LATENCY_RESET 6'h09
// Column to column delay allowed only with one-clock read preamble.
`define CCD_ONE_PRE_ONLY 4'h5
// Least write latency advance with two-clock write preamble.
`define CWL_TWO_PRE_EXTRA 6'h01
// Data path width and buffer depth.
`define DATA_WIDTH 16
`define FIFO_DEPTH 8
`define FIFO_ADDR_W 3
`endif

// ### rtl/sync_fifo.v
// Synchronous FIFO with valid and ready on both sides.
`timescale 1ns/10ps
module sync_fifo #(
    parameter WIDTH = 16,
    parameter DEPTH = 8,
    parameter AW = 3
) (
    input wire sys_clk_i,
    input wire reset_i,
    input wire [WIDTH-1:0] in_data_i,
    input wire in_valid_i,
    output wire in_ready_o,
    output reg [WIDTH-1:0] out_data_o,
    output wire out_valid_o,
    input wire out_ready_i
);
    // Storage array, one word per entry.
    reg [WIDTH-1:0] mem_r [0:DEPTH-1];
    reg [AW-1:0] wr_ptr_r;
    reg [AW-1:0] rd_ptr_r;
    // Count is one bit wider so full and empty stay honest.
    reg [AW:0] count_r;
    wire push;
    wire pop;

    assign in_ready_o = (count_r != DEPTH);
    assign out_valid_o = (count_r != 0);
    assign push = in_valid_i & in_ready_o;
    assign pop = out_valid_o & out_ready_i;

    // =========================================================
    // Pointer, count and storage update.
    always @(posedge sys_clk_i) begin
        if (reset_i) begin
            wr_ptr_r <= {AW{1'b0}};
            rd_ptr_r <= {AW{1'b0}};
            count_r <= {(AW+1){1'b0}};
        end else begin
            if (push) begin
                mem_r[wr_ptr_r] <= in_data_i;
                wr_ptr_r <= wr_ptr_r + 1'b1;
            end
            if (pop) begin
                rd_ptr_r <= rd_ptr_r + 1'b1;
            end
            if (push && !pop) begin
                count_r <= count_r + 1'b1;
            end else if (pop && !push) begin
                count_r <= count_r - 1'b1;
            end
        end
    end

    // Head word is read straight from the array at the read pointer.
    always @* begin
        out_data_o = mem_r[rd_ptr_r];
    end
endmodule

// ### rtl/burst_sequencer.v
// Read and write burst sequencer for a synchronous DRAM data path.
`timescale 1ns/10ps
`include "burst_seq_regs.vh"
module burst_sequencer (
    input wire sys_clk_i,
    input wire reset_i,
    // Command strobes and the chop select address bit, same clock.
    input wire read_cmd_i,
    input wire write_cmd_i,
    input wire chop_select_address_bit_i,
    // Mode register zero burst field and latencies.
    input wire [1:0] mode_register_zero_burst_i,
    input wire [5:0] read_latency_i,
    input wire [5:0] write_latency_i,
    input wire two_clk_read_preamble_i,
    input wire two_clk_write_preamble_i,
    input wire [5:0] min_write_cas_latency_i,
    // Read data source from the array, one word per beat.
    input wire [`DATA_WIDTH-1:0] array_data_i,
    output wire array_ready_o,
    input wire array_valid_i,
    // Read data out.
    output reg [`DATA_WIDTH-1:0] read_data_o,
    output reg read_valid_o,
    output reg read_chop_o,
    // Write data in and beat strobe.
    input wire [`DATA_WIDTH-1:0] write_data_i,
    output reg [`DATA_WIDTH-1:0] write_data_o,
    output reg write_valid_o,
    output reg write_chop_o,
    // Controller spacing warnings.
    output reg ccd_violation_o,
    output reg write_latency_low_o
);
    // =========================================================
    // Burst length decode.
    // Chop decision for the command presented in this cycle.
    reg chop_now;
    always @* begin
        case (mode_register_zero_burst_i)
            `BURST_FIXED_EIGHT: chop_now = 1'b0;
            `BURST_FIXED_CHOP: chop_now = 1'b1;
            // Chop bit is sampled afresh with each command.
            `BURST_PER_COMMAND: chop_now = ~chop_select_address_bit_i;
            default: chop_now = 1'b0;
        endcase
    end

    // =========================================================
    // Read latency pipeline: one slot per clock of latency.
    // A shift line lets several reads be in flight, so reads spaced by
    // the burst duration come out with no idle cycles between them.
    reg [`READ_LATENCY_MAX:0] rd_start_r;
    reg [`READ_LATENCY_MAX:0] rd_chop_r;
    wire rd_due;
    wire rd_due_chop;
    always @(posedge sys_clk_i) begin
        if (reset_i) begin
            rd_start_r <= {(`READ_LATENCY_MAX+1){1'b0}};
            rd_chop_r <= {(`READ_LATENCY_MAX+1){1'b0}};
        end else begin
            rd_start_r <= {rd_start_r[`READ_LATENCY_MAX-1:0], read_cmd_i};
            rd_chop_r <= {rd_chop_r[`READ_LATENCY_MAX-1:0],
                          read_cmd_i & chop_now};
        end
    end
    // Tap zero holds the command one clock after its cycle, so latency L picks tap L-1.
    assign rd_due = (read_latency_i == 6'h00) ? read_cmd_i :
                    rd_start_r[read_latency_i - 6'h01];
    assign rd_due_chop = (read_latency_i == 6'h00) ? (read_cmd_i & chop_now) :
                         rd_chop_r[read_latency_i - 6'h01];

    // =========================================================
    // Read beat counter.
    reg [3:0] rd_beats_r;
    reg rd_chop_cur_r;
    wire rd_busy;
    assign rd_busy = (rd_beats_r != 4'h0);
    // Pull a word from the buffer for every beat sent.
    wire rd_beat;
    assign rd_beat = rd_busy | rd_due;

    // =========================================================
    // Read data buffer between the array and the beat output.
    // The buffer absorbs the array's own pace, so a burst that is due
    // finds its words waiting and the strobe does not stall mid-burst.
    // Head word of the buffer, offered to the beat output.
    wire [`DATA_WIDTH-1:0] buf_data;
    // High while the buffer holds at least one word.
    wire buf_valid;
    sync_fifo #(
        .WIDTH(`DATA_WIDTH),
        .DEPTH(`FIFO_DEPTH),
        .AW(`FIFO_ADDR_W)
    ) u_read_buf (
        .sys_clk_i(sys_clk_i),
        .reset_i(reset_i),
        .in_data_i(array_data_i),
        .in_valid_i(array_valid_i),
        .in_ready_o(array_ready_o),
        .out_data_o(buf_data),
        .out_valid_o(buf_valid),
        .out_ready_i(rd_beat)
    );

    always @(posedge sys_clk_i) begin
        if (reset_i) begin
            rd_beats_r <= 4'h0;
            rd_chop_cur_r <= 1'b0;
            read_data_o <= {`DATA_WIDTH{1'b0}};
            read_valid_o <= 1'b0;
            read_chop_o <= 1'b0;
        end else begin
            // A new burst due on the last beat of the old one starts at
            // once, so the strobe never idles between them.
            if (rd_due && (rd_beats_r <= 4'h1)) begin
                rd_beats_r <= (rd_due_chop ? `BEATS_CHOP : `BEATS_EIGHT)
                              - 4'h1;
                rd_chop_cur_r <= rd_due_chop;
            end else if (rd_busy) begin
                rd_beats_r <= rd_beats_r - 4'h1;
            end
            read_valid_o <= rd_beat & buf_valid;
            if (rd_beat) begin
                read_data_o <= buf_data;
            end
            read_chop_o <= (rd_due && (rd_beats_r <= 4'h1)) ? rd_due_chop
                           : rd_chop_cur_r;
        end
    end

    // =========================================================
    // Write burst: latency line and beat counter, like the read side.
    reg [`READ_LATENCY_MAX:0] wr_start_r;
    reg [`READ_LATENCY_MAX:0] wr_chop_r;
    reg [3:0] wr_beats_r;
    reg wr_chop_cur_r;
    wire wr_due;
    wire wr_due_chop;
    always @(posedge sys_clk_i) begin
        if (reset_i) begin
            wr_start_r <= {(`READ_LATENCY_MAX+1){1'b0}};
            wr_chop_r <= {(`READ_LATENCY_MAX+1){1'b0}};
        end else begin
            wr_start_r <= {wr_start_r[`READ_LATENCY_MAX-1:0], write_cmd_i};
            wr_chop_r <= {wr_chop_r[`READ_LATENCY_MAX-1:0],
                          write_cmd_i & chop_now};
        end
    end
    assign wr_due = (write_latency_i == 6'h00) ? write_cmd_i :
                    wr_start_r[write_latency_i - 6'h01];
    assign wr_due_chop = (write_latency_i == 6'h00) ?
                         (write_cmd_i & chop_now) :
                         wr_chop_r[write_latency_i - 6'h01];

    // Write data is captured from the controller every cycle, beat or not.
    always @(posedge sys_clk_i) begin
        if (reset_i) begin
            wr_beats_r <= 4'h0;
            wr_chop_cur_r <= 1'b0;
            write_data_o <= {`DATA_WIDTH{1'b0}};
            write_valid_o <= 1'b0;
            write_chop_o <= 1'b0;
        end else begin
            if (wr_due && (wr_beats_r <= 4'h1)) begin
                wr_beats_r <= (wr_due_chop ? `BEATS_CHOP : `BEATS_EIGHT)
                              - 4'h1;
                wr_chop_cur_r <= wr_due_chop;
            end else if (wr_beats_r != 4'h0) begin
                wr_beats_r <= wr_beats_r - 4'h1;
            end
            write_valid_o <= wr_due | (wr_beats_r != 4'h0);
            write_data_o <= write_data_i;
            write_chop_o <= (wr_due && (wr_beats_r <= 4'h1)) ? wr_due_chop
                            : wr_chop_cur_r;
        end
    end

    // =========================================================
    // Spacing checks on the controller, reported as flags only.
    // The device does not refuse a badly spaced read; it only warns.
    reg [3:0] since_read_r;
    always @(posedge sys_clk_i) begin
        if (reset_i) begin
            since_read_r <= 4'hf;
            ccd_violation_o <= 1'b0;
            write_latency_low_o <= 1'b0;
        end else begin
            if (read_cmd_i) begin
                since_read_r <= 4'h1;
            end else if (since_read_r != 4'hf) begin
                since_read_r <= since_read_r + 4'h1;
            end
            // Spacing of five is legal only with one-clock preamble.
            ccd_violation_o <= read_cmd_i & two_clk_read_preamble_i &
                (since_read_r == `CCD_ONE_PRE_ONLY);
            // Two-clock write preamble wants latency above the floor.
            write_latency_low_o <= two_clk_write_preamble_i &
                (write_latency_i < (min_write_cas_latency_i +
                 `CWL_TWO_PRE_EXTRA));
        end
    end
endmodule

// ### sim/burst_seq_assertions.sv
// Concurrent checks on the burst sequencer ports.
`timescale 1ns/10ps
module burst_seq_assertions (
    input wire sys_clk_i,
    input wire reset_i,
    input wire read_cmd_i,
    input wire write_cmd_i,
    input wire chop_select_address_bit_i,
    input wire [1:0] mode_register_zero_burst_i,
    input wire [5:0] read_latency_i,
    input wire [5:0] write_latency_i,
    input wire two_clk_read_preamble_i,
    input wire two_clk_write_preamble_i,
    input wire [5:0] min_write_cas_latency_i,
    input wire read_valid_o,
    input wire read_chop_o,
    input wire write_valid_o,
    input wire write_chop_o,
    input wire ccd_violation_o,
    input wire write_latency_low_o
);
// Burst timing is judged only at a latency of two clocks.
default clocking cb @(posedge sys_clk_i); endclocking
default disable iff (reset_i);
wire per_command_burst_select = mode_register_zero_burst_i == 2'h1;
wire eight = mode_register_zero_burst_i != 2'h2 &&
    (!per_command_burst_select || chop_select_address_bit_i);
wire rd = read_cmd_i && read_latency_i == 6'h02;
wire wl_bad = two_clk_write_preamble_i &&
    {1'b0, write_latency_i} < {1'b0, min_write_cas_latency_i} + 7'h01;
a_read_eight:
assert property (rd && eight |-> ##3 (read_valid_o && !read_chop_o) [*8])
    else $error("eight-beat read burst wrong");
a_read_chop:
assert property (rd && !eight |-> ##3 (read_valid_o && read_chop_o) [*4])
    else $error("chopped read burst wrong");
a_write_chop:
assert property (write_cmd_i && write_latency_i == 6'h02 && per_command_burst_select &&
    !chop_select_address_bit_i |-> ##3 (write_valid_o && write_chop_o) [*4])
    else $error("chopped write burst wrong");
a_spacing_flag:
assert property (rd && two_clk_read_preamble_i && $past(read_cmd_i, 5)
    |-> ##[1:2] ccd_violation_o) else $error("spacing five not flagged");
a_wl_low:
assert property (wl_bad [*2] |-> write_latency_low_o)
    else $error("low write latency not flagged");
c_chop: cover property (rd && per_command_burst_select && !chop_select_address_bit_i);
c_flag: cover property (ccd_violation_o);
c_wchop: cover property (write_valid_o && write_chop_o);
endmodule

// ### sim/dram_ctl_model.sv
// Controller model issuing command strobes to the sequencer.
`timescale 1ns/10ps
module dram_ctl_model (
    input wire sys_clk_i,
    output reg read_cmd_o = 1'b0,
    output reg write_cmd_o = 1'b0,
    output reg chop_o = 1'b0
);
// One-cycle strobe; the chop bit goes to its inverse once released.
task issue(input wr, input ch);
    begin
        read_cmd_o = !wr;
        write_cmd_o = wr;
        chop_o = ch;
        @(negedge sys_clk_i);
        read_cmd_o = 1'b0;
        write_cmd_o = 1'b0;
        chop_o = !ch;
    end
endtask
endmodule

// ### sim/burst_sequencer_tb.sv
// Bench for the burst sequencer fed through the data buffer.
`timescale 1ns/10ps
module burst_sequencer_tb;
reg sys_clk_i = 1'b0;
reg reset_i = 1'b1;
reg [1:0] mode = 2'h0;
reg [5:0] wl = 6'h02;
reg [5:0] min_wl = 6'h01;
reg pre_rd = 1'b0;
reg pre_wr = 1'b0;
reg [15:0] fdata = 16'h0000;
integer feed_left = 0;
integer error_cnt = 0;
integer total_checks = 0;
integer run_n;
integer i;
reg run_c;
reg seen;
reg [15:0] run_d0, run_d;
wire read_cmd_i, write_cmd_i, chop, array_valid_i;
wire array_ready_o, read_valid_o, read_chop_o, write_valid_o;
wire write_chop_o, ccd_violation_o, write_latency_low_o;
wire [15:0] array_data_i, read_data_o;
assign array_valid_i = (feed_left != 0);
assign array_data_i = fdata;
always #2.5 sys_clk_i = ~sys_clk_i;
// Feeder holds each counting word until the buffer takes it.
always @(posedge sys_clk_i) begin
    if (array_valid_i && array_ready_o) begin
        fdata <= fdata + 16'h0001;
        feed_left <= feed_left - 1;
    end
end
dram_ctl_model u_ctl (.sys_clk_i, .read_cmd_o(read_cmd_i),
    .write_cmd_o(write_cmd_i), .chop_o(chop));
burst_sequencer u_dut (.sys_clk_i, .reset_i, .read_cmd_i, .write_cmd_i,
    .chop_select_address_bit_i(chop), .mode_register_zero_burst_i(mode),
    .read_latency_i(6'h02), .write_latency_i(wl),
    .two_clk_read_preamble_i(pre_rd), .two_clk_write_preamble_i(pre_wr),
    .min_write_cas_latency_i(min_wl), .array_data_i, .array_ready_o,
    .array_valid_i, .read_data_o, .read_valid_o, .read_chop_o,
    .write_data_i(16'h5a5a), .write_data_o(), .write_valid_o,
    .write_chop_o, .ccd_violation_o, .write_latency_low_o);
task check(input [31:0] got, input [31:0] exp, input [63:0] what);
    begin
        total_checks = total_checks + 1;
        if (got !== exp) begin
            error_cnt = error_cnt + 1;
            $display("[FAIL] %0s expected %0h seen %0h", what, exp, got);
        end
    end
endtask
// Waits for a read or write run and counts its unbroken beats.
task get_run(input w);
    begin
        run_n = 0;
        while ((w ? write_valid_o : read_valid_o) !== 1'b1 && run_n < 40) begin
            @(negedge sys_clk_i);
            run_n = run_n + 1;
        end
        run_n = 0;
        run_c = w ? write_chop_o : read_chop_o;
        run_d0 = read_data_o;
        while ((w ? write_valid_o : read_valid_o) === 1'b1 && run_n < 40) begin
            run_d = read_data_o;
            run_n = run_n + 1;
            @(negedge sys_clk_i);
        end
    end
endtask
task end_of_test;
    begin
        $display("checks %0d errors %0d", total_checks, error_cnt);
        if (error_cnt == 0 && total_checks > 0)
            $display("Test passed");
        else
            $display("Test failed");
        $finish;
    end
endtask
// Fill the buffer until it refuses, stall, then drain it by one read.
task t_fill_drain;
    begin
    feed_left = 20;
    repeat (15) @(negedge sys_clk_i);
    check(array_ready_o, 0, "full");
    check(feed_left, 12, "taken");
    feed_left = 0;
    u_ctl.issue(1'b0, 1'b1);
    get_run(1'b0);
    check(run_n, 8, "beats");
    check({run_d0, run_d}, 32'h00000007, "order");
    check(array_ready_o, 1, "room");
    end
endtask
// Each burst field value, per-command with both chop bits, one read each.
task t_modes;
    begin
    feed_left = 1000;
    repeat (10) @(negedge sys_clk_i);
    for (i = 0; i < 5; i = i + 1) begin
        mode = (i == 0) ? 2'h0 : (i < 3) ? 2'h1 : i[1:0] - 2'h1;
        seen = i == 2 || i == 3;
        u_ctl.issue(1'b0, i == 1 || i == 3);
        get_run(1'b0);
        check(run_n, seen ? 4 : 8, "beats");
        check(run_c, seen, "chop");
    end
    end
endtask
// Per-command lengths 8, 4, 8 spaced by their own length.
task t_gapless;
    begin
    mode = 2'h1;
    fork
        begin
            u_ctl.issue(1'b0, 1'b1);
            repeat (7) @(negedge sys_clk_i);
            u_ctl.issue(1'b0, 1'b0);
            repeat (3) @(negedge sys_clk_i);
            u_ctl.issue(1'b0, 1'b1);
        end
        get_run(1'b0);
    join
    check(run_n, 20, "gapless");
    end
endtask
// Per-command write lengths, chopped then eight.
task t_writes;
    begin
    for (i = 0; i < 2; i = i + 1) begin
        u_ctl.issue(1'b1, i[0]);
        get_run(1'b1);
        check(run_n, i ? 8 : 4, "wbeats");
        check(run_c, !i, "wchop");
    end
    end
endtask
// Long read preamble: spacing of five is broken on purpose, six is legal.
task t_spacing;
    begin
    mode = 2'h2;
    pre_rd = 1'b1;
    for (i = 5; i < 7; i = i + 1) begin
        u_ctl.issue(1'b0, 1'b1);
        repeat (i - 1) @(negedge sys_clk_i);
        u_ctl.issue(1'b0, 1'b1);
        seen = 1'b0;
        repeat (3) begin
            seen = seen | ccd_violation_o;
            @(negedge sys_clk_i);
        end
        check(seen, i == 5, "ccd");
        repeat (12) @(negedge sys_clk_i);
    end
    pre_rd = 1'b0;
    end
endtask
// Two-clock write preamble against the write latency floor.
task t_wl_floor;
    begin
    pre_wr = 1'b1;
    min_wl = 6'h02;
    repeat (3) @(negedge sys_clk_i);
    check(write_latency_low_o, 1, "wllow");
    wl = 6'h03;
    repeat (3) @(negedge sys_clk_i);
    check(write_latency_low_o, 0, "wlok");
    end
endtask
initial begin
    repeat (12) @(negedge sys_clk_i);
    reset_i = 1'b0;
    t_fill_drain;
    t_modes;
    t_gapless;
    t_writes;
    t_spacing;
    t_wl_floor;
    end_of_test;
end
// Watchdog: the run needs some 200 clocks, so 4000 means a hang.
initial begin
    #20000;
    error_cnt = error_cnt + 1;
    end_of_test;
end
endmodule
bind burst_sequencer burst_seq_assertions u_chk (.sys_clk_i, .reset_i,
    .read_cmd_i, .write_cmd_i, .chop_select_address_bit_i,
    .mode_register_zero_burst_i, .read_latency_i, .write_latency_i,
    .two_clk_read_preamble_i, .two_clk_write_preamble_i,
    .min_write_cas_latency_i, .read_valid_o, .read_chop_o, .write_valid_o,
    .write_chop_o, .ccd_violation_o, .write_latency_low_o);
